// ===== verilog/rio_pkg.sv
// Package: register map, field positions, reset values and timing constants of the interrupt output block
package rio_pkg;
	// Register offsets
	localparam logic [3:0] INTERRUPT_CONTROL_OFS = 4'hE;
	localparam logic [3:0] INTERRUPT_FLAGS_OFS   = 4'hF;
	// Control register fields
	localparam int FIRST_ALARM_ENABLE_BIT  = 7;
	localparam int SECOND_ALARM_ENABLE_BIT = 6;
	localparam int ROUTE_SELECT_HI_BIT     = 5;
	localparam int ROUTE_SELECT_LO_BIT     = 4;
	localparam int CYCLE_SEL_LSB           = 0;
	// Flag register fields
	localparam int CLK32_DISABLE_N_BIT     = 3;
	localparam int PERIODIC_IRQ_FLAG_BIT   = 2;
	localparam int FIRST_ALARM_FLAG_BIT    = 1;
	localparam int SECOND_ALARM_FLAG_BIT   = 0;
	// Values after reset
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] FLAGS_RESET   = 8'h00;
	// Pulse mode falling edge lag after second count-up, and its cycle count
	localparam int PULSE_LAG_NS     = 92_000;
	localparam int CLK_PERIOD_NS    = 10;
	localparam int PULSE_LAG_CYCLES = (PULSE_LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		RIO_CYC_OFF    = 3'h0,
		RIO_CYC_LOW    = 3'h1,
		RIO_CYC_2HZ    = 3'h2,
		RIO_CYC_1HZ    = 3'h3,
		RIO_CYC_SEC    = 3'h4,
		RIO_CYC_MIN    = 3'h5,
		RIO_CYC_HOUR   = 3'h6,
		RIO_CYC_MONTH  = 3'h7
	} rio_cycle_e;

	// Calendar fields an alarm looks at
	typedef struct packed {
		logic [2:0] dow;
		logic [5:0] hour;
		logic [6:0] minute;
	} rio_alarm_time_s;

	// Timebase ticks from the counter chain
	typedef struct packed {
		logic sec_inc;
		logic half_sec;
		logic quarter_sec;
		logic min_zero;
		logic hour_zero;
		logic month_start;
	} rio_tick_s;

	typedef enum logic [1:0] {
		RIO_PW_IDLE = 2'b00,
		RIO_PW_WAIT = 2'b01,
		RIO_PW_LOW  = 2'b11
	} rio_pulse_e;
endpackage

// ===== verilog/rio_alarm_cmp.sv
// Alarm comparator: one flag per alarm unit, set on calendar match while enabled
`timescale 1ns/1ns
module rio_alarm_cmp (
	// Clock and reset
	input  wire logic                     i_clk_sys,
	input  wire logic                     i_rst,
	// Control
	input  wire logic                     i_enable,
	input  wire logic                     i_flag_wr,
	input  wire logic                     i_flag_wdata,
	// Times
	input  wire rio_pkg::rio_alarm_time_s i_alarm,
	input  wire rio_pkg::rio_alarm_time_s i_now,
	// Result
	output logic                          o_flag
);
	wire match_now;
	logic match_r;
	logic flag_nxt;

	assign match_now = (i_alarm == i_now);
	// Only the first cycle of a coincidence sets the flag, so a host clear holds for the rest of that minute
	wire rise = match_now & ~match_r;

	always_comb begin
		flag_nxt = o_flag;
		if (i_flag_wr)
			flag_nxt = i_flag_wdata;
		if (~i_enable)
			flag_nxt = 1'b0;
		else if (rise)
			flag_nxt = 1'b1;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_flag  <= 1'b0;
			match_r <= 1'b0;
		end else begin
			o_flag  <= flag_nxt;
			match_r <= match_now;
		end
	end

	a_alarm_set: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_enable && match_now && !match_r |=> o_flag) else $error("alarm match did not set flag");
	a_alarm_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!i_enable |=> !o_flag) else $error("disabled alarm flag set");
endmodule

// ===== verilog/rio_irq_out.sv
// Interrupt and clock output logic: alarms, periodic generator, routing, crystal clock gate
//
// Functional notes
// - Enabled alarm pulls its pin low when alarm time equals calendar.
// - Alarm match covers day-of-week, hour and minute for both alarms.
// - Alarm flag is inverse of its pin drive; flag or enable writes steer it.
// - First alarm flag at flags bit 1, enable at control bit 7.
// - Second alarm flag at flags bit 0, enable at control bit 6.
// - A pin is low when any source routed to it is active.
// - Oscillator halt clears alarm enables and cycle field; pin one released, pin two carries the crystal clock.
// - Cycle 000 off, 001 held low, 010 2 Hz, 011 1 Hz pulses.
// - Level codes fire each second, minute, hour, or month start.
// - Level mode falling edge lines up with the seconds increment.
// - Pulse durations follow the crystal timebase ticks supplied.
// - Trimming may shift periodic timing; it arrives through the ticks.
// - Pulse mode falling edge lags the seconds increment by about 92 us.
// - Two-pin variant: second pin carries crystal clock unless disable bit set.
// - Single-pin variant: dedicated clock pin gated by disable bit.
// - Clock output passes raw oscillator clock, untouched by trimming.
// - After oscillator halt the crystal clock is output by default.
// - Route field moves second alarm and/or periodic interrupt to pin two.
// - Level mode flag and low output persist until host writes zero.
`timescale 1ns/1ns
module rio_irq_out #(
	parameter bit TWO_PIN       = 1'b1,
	parameter int LAG_CYCLES    = rio_pkg::PULSE_LAG_CYCLES
) (
	// Clock and reset
	input  wire logic                     i_clk_sys,
	input  wire logic                     i_rst,
	// Oscillator halt condition and raw crystal clock level
	input  wire logic                     i_osc_halt_flag,
	input  wire logic                     i_crystal_clk,
	// Register port
	input  wire logic [3:0]               i_reg_addr,
	input  wire logic                     i_reg_wr,
	input  wire logic [7:0]               i_reg_wdata,
	output logic [7:0]                    o_reg_rdata,
	// Calendar and alarm times
	input  wire rio_pkg::rio_alarm_time_s i_now,
	input  wire rio_pkg::rio_alarm_time_s i_alarm_first,
	input  wire rio_pkg::rio_alarm_time_s i_alarm_second,
	input  wire rio_pkg::rio_tick_s       i_tick,
	// Open-drain pins, enable high while driving low
	output logic                          o_irq_pin_first_oe,
	output logic                          o_irq_pin_second_oe,
	output logic                          o_irq_pin_first_out,
	output logic                          o_irq_pin_second_out,
	output logic                          o_crystal_clock_out_oe,
	output logic                          o_crystal_clock_out_out
);
	localparam int LAG_W = $clog2(LAG_CYCLES + 1);

	logic [7:0] control_r;
	logic       clk32_disable_n_r;
	logic       periodic_flag_r;
	logic       half_phase_r;
	logic       level_flag_r;
	rio_pkg::rio_pulse_e pw_state_r;
	logic [LAG_W-1:0]    lag_cnt_r;
	logic       first_flag;
	logic       second_flag;

	// Register decode
	wire wr_ctrl  = i_reg_wr && (i_reg_addr == rio_pkg::INTERRUPT_CONTROL_OFS);
	wire wr_flags = i_reg_wr && (i_reg_addr == rio_pkg::INTERRUPT_FLAGS_OFS);
	wire clear_all = i_rst | i_osc_halt_flag;

	wire first_en  = control_r[rio_pkg::FIRST_ALARM_ENABLE_BIT];
	wire second_en = control_r[rio_pkg::SECOND_ALARM_ENABLE_BIT];
	wire [1:0] route = {control_r[rio_pkg::ROUTE_SELECT_HI_BIT], control_r[rio_pkg::ROUTE_SELECT_LO_BIT]};
	rio_pkg::rio_cycle_e cycle;
	assign cycle = rio_pkg::rio_cycle_e'(control_r[rio_pkg::CYCLE_SEL_LSB +: 3]);
	wire level_mode = cycle[2];
	wire pulse_mode = (cycle == rio_pkg::RIO_CYC_2HZ) || (cycle == rio_pkg::RIO_CYC_1HZ);

	// Level mode trigger, taken in the cycle of the seconds increment
	logic level_hit;
	always_comb begin
		level_hit = 1'b0;
		unique case (cycle)
			rio_pkg::RIO_CYC_SEC:   level_hit = i_tick.sec_inc;
			rio_pkg::RIO_CYC_MIN:   level_hit = i_tick.sec_inc & i_tick.min_zero;
			rio_pkg::RIO_CYC_HOUR:  level_hit = i_tick.sec_inc & i_tick.hour_zero;
			rio_pkg::RIO_CYC_MONTH: level_hit = i_tick.sec_inc & i_tick.month_start;
			rio_pkg::RIO_CYC_OFF, rio_pkg::RIO_CYC_LOW,
			rio_pkg::RIO_CYC_2HZ, rio_pkg::RIO_CYC_1HZ: level_hit = 1'b0;
		endcase
	end

	// Level flag: set wins over a host clear in the same cycle
	wire level_flag_nxt = level_mode & (level_hit |
		(level_flag_r & ~(wr_flags & ~i_reg_wdata[rio_pkg::PERIODIC_IRQ_FLAG_BIT])));

	// Pulse mode: the low phase starts a fixed lag after each period tick and ends half a period later
	wire pulse_start = (cycle == rio_pkg::RIO_CYC_2HZ) ? (i_tick.sec_inc | i_tick.half_sec) : i_tick.sec_inc;
	wire lag_done    = (lag_cnt_r == LAG_W'(LAG_CYCLES - 1));
	// 2 Hz ends on the quarter ticks, 1 Hz on the half second; both periods stay at half duty
	wire pulse_end   = (cycle == rio_pkg::RIO_CYC_2HZ) ? i_tick.quarter_sec : i_tick.half_sec;

	always_ff @(posedge i_clk_sys) begin
		if (clear_all || !pulse_mode) begin
			pw_state_r <= rio_pkg::RIO_PW_IDLE;
			lag_cnt_r  <= '0;
		end else begin
			unique case (pw_state_r)
				rio_pkg::RIO_PW_IDLE: if (pulse_start) begin
					pw_state_r <= rio_pkg::RIO_PW_WAIT;
					lag_cnt_r  <= '0;
				end
				rio_pkg::RIO_PW_WAIT: if (lag_done) begin
					pw_state_r <= rio_pkg::RIO_PW_LOW;
				end else begin
					lag_cnt_r <= lag_cnt_r + LAG_W'(1);
				end
				rio_pkg::RIO_PW_LOW: if (pulse_end) begin
					pw_state_r <= rio_pkg::RIO_PW_IDLE;
				end
				default: pw_state_r <= rio_pkg::RIO_PW_IDLE;
			endcase
		end
	end

	wire pulse_low = (pw_state_r == rio_pkg::RIO_PW_LOW);
	wire periodic_active = (cycle == rio_pkg::RIO_CYC_LOW) | pulse_low | level_flag_r;

	// Alarm units
	rio_alarm_cmp u_alarm_first (
		.i_clk_sys    (i_clk_sys),
		.i_rst        (clear_all),
		.i_enable     (first_en),
		.i_flag_wr    (wr_flags),
		.i_flag_wdata (i_reg_wdata[rio_pkg::FIRST_ALARM_FLAG_BIT]),
		.i_alarm      (i_alarm_first),
		.i_now        (i_now),
		.o_flag       (first_flag)
	);

	rio_alarm_cmp u_alarm_second (
		.i_clk_sys    (i_clk_sys),
		.i_rst        (clear_all),
		.i_enable     (second_en),
		.i_flag_wr    (wr_flags),
		.i_flag_wdata (i_reg_wdata[rio_pkg::SECOND_ALARM_FLAG_BIT]),
		.i_alarm      (i_alarm_second),
		.i_now        (i_now),
		.o_flag       (second_flag)
	);

	// Routing: on the single-pin variant everything stays on pin one
	wire second_on_b   = TWO_PIN & route[0];
	wire periodic_on_b = TWO_PIN & route[1];
	wire pin_a_low = first_flag | (second_flag & ~second_on_b) | (periodic_active & ~periodic_on_b);
	wire pin_b_irq = (second_flag & second_on_b) | (periodic_active & periodic_on_b);
	// Clock passes raw; trimming never reaches it
	wire clk_low   = ~clk32_disable_n_r & ~i_crystal_clk;
	wire pin_b_low = TWO_PIN ? (pin_b_irq | clk_low) : 1'b0;

	// Registers
	always_ff @(posedge i_clk_sys) begin
		if (clear_all) begin
			control_r         <= rio_pkg::CONTROL_RESET;
			clk32_disable_n_r <= 1'b0;
			level_flag_r      <= 1'b0;
		end else begin
			if (wr_ctrl)
				control_r <= i_reg_wdata;
			if (wr_flags)
				clk32_disable_n_r <= i_reg_wdata[rio_pkg::CLK32_DISABLE_N_BIT];
			level_flag_r <= level_flag_nxt;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_irq_pin_first_oe      <= 1'b0;
			o_irq_pin_second_oe     <= 1'b0;
			o_irq_pin_first_out     <= 1'b0;
			o_irq_pin_second_out    <= 1'b0;
			o_crystal_clock_out_oe  <= 1'b0;
			o_crystal_clock_out_out <= 1'b0;
			o_reg_rdata             <= 8'h00;
			periodic_flag_r         <= 1'b0;
		end else begin
			o_irq_pin_first_oe      <= pin_a_low;
			o_irq_pin_second_oe     <= pin_b_low;
			o_irq_pin_first_out     <= 1'b0;
			o_irq_pin_second_out    <= 1'b0;
			o_crystal_clock_out_oe  <= ~TWO_PIN & clk_low;
			o_crystal_clock_out_out <= 1'b0;
			periodic_flag_r         <= periodic_active;
			if (i_reg_addr == rio_pkg::INTERRUPT_CONTROL_OFS)
				o_reg_rdata <= control_r;
			else if (i_reg_addr == rio_pkg::INTERRUPT_FLAGS_OFS)
				o_reg_rdata <= {4'h0, clk32_disable_n_r, periodic_active, first_flag, second_flag};
			else
				o_reg_rdata <= 8'h00;
		end
	end

	// Checks
	a_halt_clears_ctrl: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_osc_halt_flag |=> control_r == 8'h00 && !clk32_disable_n_r) else $error("halt did not clear control");
	a_pin_or_sources: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		pin_a_low |=> o_irq_pin_first_oe) else $error("pin one not driven for active source");
	a_alarm_first_pin: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		first_flag |=> o_irq_pin_first_oe) else $error("first alarm not on pin one");
	a_fixed_low: assert property (@(posedge i_clk_sys) disable iff (i_rst || i_osc_halt_flag)
		cycle == rio_pkg::RIO_CYC_LOW && !periodic_on_b |=> o_irq_pin_first_oe) else $error("fixed low not driven");
	a_level_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst || i_osc_halt_flag)
		level_flag_r && level_mode && !wr_flags && !wr_ctrl |=> level_flag_r) else $error("level flag dropped");
	a_level_on_inc: assert property (@(posedge i_clk_sys) disable iff (i_rst || i_osc_halt_flag)
		level_mode && !wr_ctrl && i_tick.sec_inc && cycle == rio_pkg::RIO_CYC_SEC |=> level_flag_r)
		else $error("level not set on second");
	sequence s_lag_wait;
		pw_state_r == rio_pkg::RIO_PW_WAIT && lag_cnt_r == '0;
	endsequence
	a_pulse_lag: assert property (@(posedge i_clk_sys) disable iff (i_rst || i_osc_halt_flag || wr_ctrl)
		s_lag_wait |-> !pulse_low [*8]) else $error("pulse low too early");
	a_clk_disable: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		clk32_disable_n_r && !pin_b_irq |=> !o_irq_pin_second_oe) else $error("clock not stopped");
	a_flag_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_reg_addr == rio_pkg::INTERRUPT_FLAGS_OFS |=>
		o_reg_rdata[rio_pkg::PERIODIC_IRQ_FLAG_BIT] == $past(periodic_active))
		else $error("periodic flag read mismatch");
	a_alarm_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_reg_addr == rio_pkg::INTERRUPT_FLAGS_OFS |=>
		o_reg_rdata[rio_pkg::FIRST_ALARM_FLAG_BIT] == $past(first_flag) &&
		o_reg_rdata[rio_pkg::SECOND_ALARM_FLAG_BIT] == $past(second_flag))
		else $error("alarm flag read mismatch");
	a_ctrl_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_reg_addr == rio_pkg::INTERRUPT_CONTROL_OFS |=> o_reg_rdata == $past(control_r))
		else $error("control read mismatch");
	// A pin is released as soon as no routed source holds it
	a_pin_a_release: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!pin_a_low |=> !o_irq_pin_first_oe) else $error("pin one driven with no source");
	a_periodic_pin: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		periodic_active && !periodic_on_b |=> o_irq_pin_first_oe && periodic_flag_r)
		else $error("periodic source not on pin one");
	a_route_second: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		second_flag && second_on_b |=> o_irq_pin_second_oe) else $error("second alarm not on pin two");
	a_route_periodic: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		periodic_active && periodic_on_b |=> o_irq_pin_second_oe) else $error("periodic not on pin two");
	a_clk_on_pin: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		TWO_PIN && !clk32_disable_n_r && !i_crystal_clk |=> o_irq_pin_second_oe)
		else $error("crystal clock low not on pin two");
	a_level_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst || i_osc_halt_flag)
		level_flag_r && wr_flags && !i_reg_wdata[rio_pkg::PERIODIC_IRQ_FLAG_BIT] && !level_hit |=> !level_flag_r)
		else $error("level flag not cleared by host");
	a_month_level: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		cycle == rio_pkg::RIO_CYC_MONTH && i_tick.sec_inc && i_tick.month_start && !i_osc_halt_flag
		|=> level_flag_r) else $error("monthly level not set");
	// Lag expiry must open the low phase on the very next cycle
	sequence s_lag_full;
		pw_state_r == rio_pkg::RIO_PW_WAIT && lag_done && pulse_mode;
	endsequence
	a_lag_to_low: assert property (@(posedge i_clk_sys) disable iff (i_rst || i_osc_halt_flag)
		s_lag_full |=> pulse_low) else $error("pulse low late");
	a_pulse_end: assert property (@(posedge i_clk_sys) disable iff (i_rst || i_osc_halt_flag)
		pulse_low && pulse_end |=> !pulse_low) else $error("pulse low not ended");
	a_off_quiet: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		cycle == rio_pkg::RIO_CYC_OFF && $past(cycle == rio_pkg::RIO_CYC_OFF) |=> !periodic_flag_r)
		else $error("periodic active while off");
endmodule

// ===== verification/rio_host_model.sv
// Host side model: pull-up resolution of the open-drain interrupt pins
`timescale 1ns/1ns
module rio_host_model (
	// Pin enables from the device
	input  wire logic i_first_oe,
	input  wire logic i_second_oe,
	// Resolved pin levels
	output logic      o_pin_first,
	output logic      o_pin_second
);
	// Pull-ups hold a released pin high; nothing but the device pulls low
	assign o_pin_first  = ~i_first_oe;
	assign o_pin_second = ~i_second_oe;
endmodule

// ===== verification/tb_rio_irq_out.sv
// Testbench for the interrupt and clock output block
`timescale 1ns/1ns
module tb_rio_irq_out;
	logic                     i_clk_sys;
	logic                     i_rst;
	logic                     i_osc_halt_flag;
	logic                     i_crystal_clk;
	logic [3:0]               i_reg_addr;
	logic                     i_reg_wr;
	logic [7:0]               i_reg_wdata;
	logic [7:0]               o_reg_rdata;
	rio_pkg::rio_alarm_time_s i_now;
	rio_pkg::rio_alarm_time_s i_alarm_first;
	rio_pkg::rio_alarm_time_s i_alarm_second;
	rio_pkg::rio_tick_s       i_tick;
	logic                     first_oe;
	logic                     second_oe;
	logic                     pin_first;
	logic                     pin_second;
	logic                     pin_first_out;
	logic                     pin_second_out;
	logic                     clk_out_oe;
	logic                     clk_out_out;
	int                       mismatches;
	int                       compares;
	int                       cycles;
	logic [7:0]               v;
	localparam logic [3:0] CTL = rio_pkg::INTERRUPT_CONTROL_OFS;
	localparam logic [3:0] FLG = rio_pkg::INTERRUPT_FLAGS_OFS;

	rio_irq_out #(.TWO_PIN(1'b1), .LAG_CYCLES(10)) rio_irq_out_inst (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_osc_halt_flag(i_osc_halt_flag),
		.i_crystal_clk(i_crystal_clk), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
		.i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_now(i_now),
		.i_alarm_first(i_alarm_first), .i_alarm_second(i_alarm_second), .i_tick(i_tick),
		.o_irq_pin_first_oe(first_oe), .o_irq_pin_second_oe(second_oe),
		.o_irq_pin_first_out(pin_first_out), .o_irq_pin_second_out(pin_second_out),
		.o_crystal_clock_out_oe(clk_out_oe), .o_crystal_clock_out_out(clk_out_out));
	rio_host_model rio_host_model_inst (.i_first_oe(first_oe), .i_second_oe(second_oe),
		.o_pin_first(pin_first), .o_pin_second(pin_second));

	always #5 i_clk_sys = ~i_clk_sys;

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_reg_addr  <= a;
		i_reg_wr    <= 1'b1;
		i_reg_wdata <= d;
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge i_clk_sys);
		i_reg_addr <= a;
		repeat (2) @(posedge i_clk_sys);
		chk(o_reg_rdata, exp);
	endtask
	// Pins as {second, first}, 1 = released high
	task automatic pins(input logic [1:0] exp);
		repeat (3) @(posedge i_clk_sys);
		chk({6'h00, pin_second, pin_first}, {6'h00, exp});
	endtask
	task automatic sec_tick();
		@(posedge i_clk_sys);
		i_tick.sec_inc <= 1'b1;
		@(posedge i_clk_sys);
		i_tick.sec_inc <= 1'b0;
	endtask
	task automatic end_of_test();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Whole run needs about 260 cycles
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			end_of_test();
		end
	end

	initial begin
		mismatches = 0;
		compares = 0;
		cycles = 0;
		i_clk_sys = 1'b0;
		i_rst = 1'b1;
		i_osc_halt_flag = 1'b1;
		i_crystal_clk = 1'b1;
		i_reg_addr = 4'h0;
		i_reg_wr = 1'b0;
		i_reg_wdata = 8'h00;
		i_now = '0;
		i_alarm_first = {3'h2, 6'h09, 7'h30};
		i_alarm_second = {3'h5, 6'h17, 7'h45};
		i_tick = '0;
		repeat (20) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		i_osc_halt_flag <= 1'b0;
		rd(CTL, 8'h00);
		rd(FLG, 8'h00);
		pins(2'b11);
		i_crystal_clk <= 1'b0;
		pins(2'b01);
		chk({4'h0, clk_out_out, clk_out_oe, pin_second_out, pin_first_out}, 8'h00);
		i_crystal_clk <= 1'b1;
		pins(2'b11);
		$display("test 1 done");
		wr(FLG, 8'h08);
		i_crystal_clk <= 1'b0;
		pins(2'b11);
		rd(FLG, 8'h08);
		$display("test 2 done");
		wr(CTL, 8'h00);
		i_now <= {3'h3, 6'h09, 7'h30};
		wr(CTL, 8'h80);
		pins(2'b11);
		i_now <= i_alarm_first;
		pins(2'b10);
		rd(FLG, 8'h0A);
		wr(FLG, 8'h08);
		pins(2'b11);
		wr(CTL, 8'h40);
		i_now <= i_alarm_second;
		pins(2'b10);
		rd(FLG, 8'h09);
		wr(FLG, 8'h08);
		wr(CTL, 8'h50);
		i_now <= '0;
		pins(2'b11);
		i_now <= i_alarm_second;
		pins(2'b01);
		wr(FLG, 8'h08);
		wr(CTL, 8'h00);
		pins(2'b11);
		$display("test 3 done");
		for (int c = 4; c < 8; c++) begin
			wr(CTL, {5'h00, 3'(c)});
			if (c > 4) begin
				sec_tick();
				pins(2'b11);
			end
			i_tick.min_zero    <= (c == 5);
			i_tick.hour_zero   <= (c == 6);
			i_tick.month_start <= (c == 7);
			sec_tick();
			pins(2'b10);
			rd(FLG, 8'h0C);
			i_tick <= '0;
			sec_tick();
			pins(2'b10);
			wr(FLG, 8'h08);
			pins(2'b11);
		end
		wr(CTL, 8'h01);
		pins(2'b10);
		wr(CTL, 8'h21);
		pins(2'b01);
		wr(CTL, 8'h00);
		pins(2'b11);
		$display("test 4 done");
		wr(CTL, 8'h03);
		sec_tick();
		pins(2'b11);
		repeat (10) @(posedge i_clk_sys);
		pins(2'b10);
		rd(FLG, 8'h0C);
		@(posedge i_clk_sys);
		i_tick.half_sec <= 1'b1;
		@(posedge i_clk_sys);
		i_tick.half_sec <= 1'b0;
		pins(2'b11);
		rd(FLG, 8'h08);
		wr(CTL, 8'h02);
		sec_tick();
		repeat (12) @(posedge i_clk_sys);
		pins(2'b10);
		@(posedge i_clk_sys);
		i_tick.quarter_sec <= 1'b1;
		@(posedge i_clk_sys);
		i_tick.quarter_sec <= 1'b0;
		pins(2'b11);
		$display("test 5 done");
		@(posedge i_clk_sys);
		i_osc_halt_flag <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		i_osc_halt_flag <= 1'b0;
		rd(CTL, 8'h00);
		rd(FLG, 8'h00);
		pins(2'b01);
		$display("test 6 done");
		end_of_test();
	end
endmodule
